// [src/diag_alert_top.sv]
// Functional notes
// - The identity and calibration ROM is covered by an 8-bit CRC with polynomial x^8+x^6+x^3+x^2+1.
// - The calibration word reads the checksum in bits 15:8 and calibration data in bits 7:0, both read-only.
// - While the zero-scale check runs, any conversion result above zero sets the zero-scale alert flag.
// - Each of five force bits injects an overranged value into its calibration stage.
// - Each forced overrange sets its own calibration alert bit in the alert summary register.
// - The three low-voltage supply pins are watched and a low supply sets its open-supply flag.
// - The three ground pins are watched and an open ground sets its open-ground flag.
// - Software sets the highest used cell when fewer than 14 cells exist and alerts above it are suppressed.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
module diag_alert_top
    import diag_pkg::*;
#(
    parameter int                  ROM_WORDS = 13,
    parameter int                  ADC_W     = 14,
    parameter int                  CAL_W     = 12,
    parameter logic [CAL_W-1:0]    CAL_LIMIT = 12'h7FF,
    // Arbitrary contents
    parameter logic [15:0]         ROM_IMAGE [ROM_WORDS] = '{default: 16'h5A3C}
) (
    // Clock and reset
    input  wire logic                                     sys_clk_in,
    input  wire logic                                     arst_n_in,
    // APB slave
    input  wire logic [diag_pkg::ADDR_W-1:0]              paddr_in,
    input  wire logic                                     psel_in,
    input  wire logic                                     penable_in,
    input  wire logic                                     pwrite_in,
    input  wire logic [diag_pkg::DATA_W-1:0]              pwdata_in,
    output logic      [diag_pkg::DATA_W-1:0]              prdata_out,
    output logic                                          pready_out,
    output logic                                          pslverr_out,
    // Converter result
    input  wire logic [ADC_W-1:0]                         adc_result_in,
    input  wire logic                                     adc_valid_in,
    // Calibration stages
    input  wire logic [diag_pkg::NUM_CAL-1:0][CAL_W-1:0]  cal_value_in,
    input  wire logic [diag_pkg::NUM_CAL-1:0]             cal_valid_in,
    // Analog comparators
    input  wire logic [diag_pkg::NUM_LINES-1:0]           supply_low_in,
    input  wire logic [diag_pkg::NUM_LINES-1:0]           ground_open_in,
    input  wire logic [diag_pkg::NUM_CELLS-1:0]           cell_alert_in,
    // Interrupt and stage outputs
    output logic                                          irq_out,
    output logic      [diag_pkg::NUM_CAL-1:0][CAL_W-1:0]  cal_stage_out
);
    import diag_pkg::*;

    localparam int AW = $clog2(ROM_WORDS);

    crc_if #(.AW(AW)) crc_bus ();

    logic [NUM_CAL-1:0]        force_ff;
    logic                      zs_enable_ff;
    logic                      crc_start_ff;
    logic [7:0]                rom_checksum_ff;
    logic [HIGHEST_USED_CELL_W-1:0]      highest_used_cell_ff;
    logic [SUM_W-1:0]          alert_summary_reg_ff;
    logic [SUM_W-1:0]          mask_ff;
    logic [FAULT2_W-1:0]       fault_analysis_reg_two_ff;
    logic [NUM_CELLS-1:0]      cell_flag_ff;
    logic [NUM_LINES-1:0]      supply_meta_ff;
    logic [NUM_LINES-1:0]      supply_sync_ff;
    logic [NUM_LINES-1:0]      ground_meta_ff;
    logic [NUM_LINES-1:0]      ground_sync_ff;
    logic [NUM_CELLS-1:0]      cell_meta_ff;
    logic [NUM_CELLS-1:0]      cell_sync_ff;
    logic [DATA_W-1:0]         prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    logic                      irq_ff;
    logic [NUM_CAL-1:0][CAL_W-1:0] stage_ff;

    logic                      setup_phase;
    logic                      wr_commit;
    logic [DATA_W-1:0]         rd_mux;
    logic                      rd_hit;
    logic [NUM_CAL-1:0]        cal_over;
    logic [NUM_CELLS-1:0]      cell_used;
    logic [NUM_CELLS-1:0]      cell_set;
    logic [FAULT2_W-1:0]       fault2_set;
    logic [SUM_W-1:0]          sum_set;
    logic                      zs_event;
    logic [DATA_W-1:0]         ctrl_view;
    logic [SUM_W-1:0]          sum_clr;
    logic [FAULT2_W-1:0]       fault2_clr;
    logic [NUM_CELLS-1:0]      cell_clr;

    // ROM read port and checksum engine
    assign crc_bus.rd_data = ROM_IMAGE[crc_bus.rd_addr];
    assign crc_bus.start   = crc_start_ff;

    rom_crc_engine #(
        .ROM_WORDS (ROM_WORDS),
        .AW        (AW)
    ) u_crc (
        .clk_in    (sys_clk_in),
        .arst_n_in (arst_n_in),
        .crc_bus   (crc_bus)
    );

    // APB phases
    assign setup_phase = psel_in && !penable_in;
    assign wr_commit   = psel_in && penable_in && pready_ff && pwrite_in;

    // Supply comparator synchroniser
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            supply_meta_ff <= '0;
            supply_sync_ff <= '0;
        end else begin
            supply_meta_ff <= supply_low_in;
            supply_sync_ff <= supply_meta_ff;
        end
    end

    // Ground comparator synchroniser
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ground_meta_ff <= '0;
            ground_sync_ff <= '0;
        end else begin
            ground_meta_ff <= ground_open_in;
            ground_sync_ff <= ground_meta_ff;
        end
    end

    // Cell comparator synchroniser
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cell_meta_ff <= '0;
            cell_sync_ff <= '0;
        end else begin
            cell_meta_ff <= cell_alert_in;
            cell_sync_ff <= cell_meta_ff;
        end
    end

    // Calibration stages with forced overrange
    generate
        for (genvar s = 0; s < NUM_CAL; s++) begin : g_cal
            always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    stage_ff[s] <= '0;
                end else if (force_ff[s]) begin
                    stage_ff[s] <= '1;
                end else if (cal_valid_in[s]) begin
                    stage_ff[s] <= cal_value_in[s];
                end
            end
            assign cal_over[s] = (stage_ff[s] > CAL_LIMIT);
        end
    endgenerate

    // Cell alert masking above the highest used cell
    generate
        for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
            assign cell_used[c] = (HIGHEST_USED_CELL_W'(c) < highest_used_cell_ff);
            assign cell_set[c]  = cell_sync_ff[c] && cell_used[c];
        end
    endgenerate

    // Event sources
    assign zs_event = zs_enable_ff && adc_valid_in && (adc_result_in != '0);
    assign fault2_set[FAULT2_ZS_BIT] = zs_event;
    assign fault2_set[FAULT2_SUPPLY_LSB +: NUM_LINES] = supply_sync_ff;
    assign fault2_set[FAULT2_GROUND_LSB +: NUM_LINES] = ground_sync_ff;
    assign sum_set[CTRL_FORCE_LSB +: NUM_CAL] = cal_over;
    assign sum_set[SUM_FAULT2_BIT] = |fault2_set;
    assign sum_set[SUM_CELL_BIT]   = |cell_set;
    assign sum_set[SUM_CRC_BIT]    = crc_bus.done;

    // Control register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            force_ff     <= FORCE_RST;
            zs_enable_ff <= 1'b0;
        end else if (wr_commit && paddr_in == ADDR_CTRL) begin
            force_ff     <= pwdata_in[CTRL_FORCE_LSB +: NUM_CAL];
            zs_enable_ff <= pwdata_in[CTRL_ZS_BIT];
        end
    end

    // Recompute request pulse; the first run follows reset, a request while busy is dropped
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crc_start_ff <= 1'b1;
        end else begin
            crc_start_ff <= wr_commit && paddr_in == ADDR_CTRL && pwdata_in[CTRL_RECALC_BIT]
                && !crc_bus.busy;
        end
    end

    // Highest used cell setting
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            highest_used_cell_ff <= HIGHEST_USED_CELL_RST;
        end else if (wr_commit && paddr_in == ADDR_HIGHEST_USED_CELL) begin
            highest_used_cell_ff <= pwdata_in[HIGHEST_USED_CELL_W-1:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mask_ff <= MASK_RST;
        end else if (wr_commit && paddr_in == ADDR_MASK) begin
            mask_ff <= pwdata_in[SUM_W-1:0];
        end
    end

    // Checksum result
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rom_checksum_ff <= CRC_INIT;
        end else if (crc_bus.done) begin
            rom_checksum_ff <= crc_bus.crc;
        end
    end

    // Write-one-to-clear strobes
    assign sum_clr    = (wr_commit && paddr_in == ADDR_SUMMARY) ? pwdata_in[SUM_W-1:0] : '0;
    assign fault2_clr = (wr_commit && paddr_in == ADDR_FAULT2) ? pwdata_in[FAULT2_W-1:0] : '0;
    assign cell_clr   = (wr_commit && paddr_in == ADDR_CELL) ? pwdata_in[NUM_CELLS-1:0] : '0;

    // Alert summary, sticky, set wins over clear
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alert_summary_reg_ff <= '0;
        end else begin
            alert_summary_reg_ff <= (alert_summary_reg_ff & ~sum_clr) | sum_set;
        end
    end

    // Fault analysis flags, sticky, set wins over clear
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fault_analysis_reg_two_ff <= '0;
        end else begin
            fault_analysis_reg_two_ff <= (fault_analysis_reg_two_ff & ~fault2_clr) | fault2_set;
        end
    end

    // Cell flags, sticky, cleared above the highest used cell
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cell_flag_ff <= '0;
        end else begin
            cell_flag_ff <= ((cell_flag_ff & ~cell_clr) | cell_set) & cell_used;
        end
    end

    // Interrupt output
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(alert_summary_reg_ff & mask_ff);
        end
    end

    // Read decode
    always_comb begin
        ctrl_view = DATA_ZERO;
        ctrl_view[CTRL_FORCE_LSB +: NUM_CAL] = force_ff;
        ctrl_view[CTRL_ZS_BIT]   = zs_enable_ff;
        ctrl_view[CTRL_BUSY_BIT] = crc_bus.busy;
        rd_hit = 1'b1;
        rd_mux = DATA_ZERO;
        unique case (paddr_in)
            ADDR_CAL_WORD: rd_mux[15:0] = {rom_checksum_ff, ROM_IMAGE[ROM_WORDS-1][7:0]};
            ADDR_CTRL:     rd_mux = ctrl_view;
            ADDR_HIGHEST_USED_CELL:  rd_mux[HIGHEST_USED_CELL_W-1:0] = highest_used_cell_ff;
            ADDR_SUMMARY:  rd_mux[SUM_W-1:0] = alert_summary_reg_ff;
            ADDR_MASK:     rd_mux[SUM_W-1:0] = mask_ff;
            ADDR_FAULT2:   rd_mux[FAULT2_W-1:0] = fault_analysis_reg_two_ff;
            ADDR_CELL:     rd_mux[NUM_CELLS-1:0] = cell_flag_ff;
            default:       rd_hit = 1'b0;
        endcase
    end

    // APB response: one wait-free access phase after setup
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= DATA_ZERO;
        end else if (setup_phase) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !rd_hit || (pwrite_in && paddr_in == ADDR_CAL_WORD);
            prdata_ff  <= pwrite_in ? DATA_ZERO : rd_mux;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= DATA_ZERO;
        end
    end

    assign prdata_out    = prdata_ff;
    assign pready_out    = pready_ff;
    assign pslverr_out   = pslverr_ff;
    assign irq_out       = irq_ff;
    assign cal_stage_out = stage_ff;

endmodule : diag_alert_top

// [src/diag_pkg.sv]
package diag_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CAL_WORD = 10'h098;
    localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h0A0;
    localparam logic [IDX_W-1:0] IDX_HIGHEST_USED_CELL  = 10'h0A1;
    localparam logic [IDX_W-1:0] IDX_SUMMARY  = 10'h0A2;
    localparam logic [IDX_W-1:0] IDX_MASK     = 10'h0A3;
    localparam logic [IDX_W-1:0] IDX_FAULT2   = 10'h0A4;
    localparam logic [IDX_W-1:0] IDX_CELL     = 10'h0A5;

    localparam logic [ADDR_W-1:0] ADDR_CAL_WORD = {IDX_CAL_WORD, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_HIGHEST_USED_CELL  = {IDX_HIGHEST_USED_CELL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SUMMARY  = {IDX_SUMMARY, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MASK     = {IDX_MASK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FAULT2   = {IDX_FAULT2, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CELL     = {IDX_CELL, 2'b00};

    // Checksum
    localparam logic [7:0] CRC_POLY_KOOPMAN = 8'hA6;
    localparam logic [7:0] CRC_POLY         = {CRC_POLY_KOOPMAN[6:0], 1'b1};
    localparam logic [7:0] CRC_INIT         = 8'h00;
    localparam int         ROM_WORD_W       = 16;

    // Channel counts
    localparam int NUM_CAL   = 5;
    localparam int NUM_LINES = 3;
    localparam int NUM_CELLS = 14;
    localparam int HIGHEST_USED_CELL_W = 4;
    localparam logic [HIGHEST_USED_CELL_W-1:0] HIGHEST_USED_CELL_RST = 4'hE;

    // Control register fields
    localparam int CTRL_FORCE_LSB = 0;
    localparam int CTRL_ZS_BIT    = 5;
    localparam int CTRL_RECALC_BIT = 6;
    localparam int CTRL_BUSY_BIT  = 7;
    localparam logic [NUM_CAL-1:0] FORCE_RST = 5'h00;

    // Summary / mask fields
    localparam int SUM_W          = 8;
    localparam int SUM_FAULT2_BIT = 5;
    localparam int SUM_CELL_BIT   = 6;
    localparam int SUM_CRC_BIT    = 7;
    localparam logic [SUM_W-1:0] MASK_RST = 8'h00;

    // Fault analysis register two fields
    localparam int FAULT2_W          = 7;
    localparam int FAULT2_ZS_BIT     = 0;
    localparam int FAULT2_SUPPLY_LSB = 1;
    localparam int FAULT2_GROUND_LSB = 4;

    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {crc_idle_s, crc_run_s} crc_state_t;

endpackage : diag_pkg

// [src/crc_if.sv]
`timescale 1ns/1ns
interface crc_if #(parameter int AW = 4);
    logic                              start;
    logic                              busy;
    logic                              done;
    logic [AW-1:0]                     rd_addr;
    logic [diag_pkg::ROM_WORD_W-1:0]   rd_data;
    logic [7:0]                        crc;

    modport engine (input start, input rd_data, output busy, output done, output rd_addr, output crc);
    modport ctrl   (output start, output rd_data, input busy, input done, input rd_addr, input crc);
endinterface : crc_if

// [src/rom_crc_engine.sv]
`timescale 1ns/1ns
module rom_crc_engine #(
    parameter int ROM_WORDS = 13,
    parameter int AW        = 4
) (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    crc_if.engine     crc_bus
);
    import diag_pkg::*;

    crc_state_t    state_ff;
    logic [AW-1:0] addr_ff;
    logic [7:0]    crc_ff;
    logic          done_ff;
    logic          last_word;

    function automatic logic [7:0] crc_byte(input logic [7:0] c_in, input logic [7:0] b);
        logic [7:0] c;
        logic       fb;
        c = c_in;
        for (int i = 7; i >= 0; i--) begin
            fb = c[7] ^ b[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc_byte

    assign last_word       = (addr_ff == AW'(ROM_WORDS - 1));
    assign crc_bus.rd_addr = addr_ff;
    assign crc_bus.busy    = (state_ff == crc_run_s);
    assign crc_bus.done    = done_ff;
    assign crc_bus.crc     = crc_ff;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= crc_idle_s;
            addr_ff  <= '0;
            crc_ff   <= CRC_INIT;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                crc_idle_s: begin
                    if (crc_bus.start) begin
                        state_ff <= crc_run_s;
                        addr_ff  <= '0;
                        crc_ff   <= CRC_INIT;
                    end
                end
                crc_run_s: begin
                    if (last_word) begin
                        // Last word: only its low calibration byte is covered
                        crc_ff   <= crc_byte(crc_ff, crc_bus.rd_data[7:0]);
                        state_ff <= crc_idle_s;
                        done_ff  <= 1'b1;
                    end else begin
                        // High byte then low byte, ascending addresses
                        crc_ff  <= crc_byte(crc_byte(crc_ff, crc_bus.rd_data[15:8]), crc_bus.rd_data[7:0]);
                        addr_ff <= addr_ff + AW'(1);
                    end
                end
            endcase
        end
    end

endmodule : rom_crc_engine

// [verif/diag_alert_monitor.sv]
`timescale 1ns/1ns
module diag_alert_monitor
    import diag_pkg::*;
#(
    parameter int CAL_W = 12
) (
    // Clock and reset
    input  wire logic                                    sys_clk_in,
    input  wire logic                                    arst_n_in,
    // APB
    input  wire logic [diag_pkg::ADDR_W-1:0]             paddr_in,
    input  wire logic                                    psel_in,
    input  wire logic                                    penable_in,
    input  wire logic                                    pwrite_in,
    input  wire logic [diag_pkg::DATA_W-1:0]             pwdata_in,
    input  wire logic [diag_pkg::DATA_W-1:0]             prdata_out,
    input  wire logic                                    pready_out,
    input  wire logic                                    pslverr_out,
    // Outputs
    input  wire logic                                    irq_out,
    input  wire logic [diag_pkg::NUM_CAL-1:0][CAL_W-1:0] cal_stage_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence reg_write(logic [ADDR_W-1:0] a);
        psel_in && penable_in && pready_out && pwrite_in && paddr_in == a;
    endsequence

    chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("ready missing after setup");
    chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    chk_rdata_idle_zero: assert property (!pready_out |-> prdata_out == DATA_ZERO)
        else $error("read data not zero outside access");
    chk_upper_bits_zero: assert property (pready_out && !pwrite_in |-> prdata_out[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_cal_word_refused: assert property (reg_write(ADDR_CAL_WORD) |-> pslverr_out)
        else $error("write to calibration word not refused");
    chk_error_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    chk_irq_mask_off: assert property (reg_write(ADDR_MASK) ##0 pwdata_in == DATA_ZERO |-> ##3 !irq_out)
        else $error("interrupt high with mask cleared");
    for (genvar s = 0; s < NUM_CAL; s++) begin : g_force
        chk_stage_forced: assert property (reg_write(ADDR_CTRL) ##0 pwdata_in[s] |-> ##[1:2] cal_stage_out[s] == '1)
            else $error("stage not forced to overrange");
    end
endmodule : diag_alert_monitor

bind diag_alert_top diag_alert_monitor #(.CAL_W(CAL_W)) u_diag_alert_monitor (
    .sys_clk_in    (sys_clk_in),
    .arst_n_in     (arst_n_in),
    .paddr_in      (paddr_in),
    .psel_in       (psel_in),
    .penable_in    (penable_in),
    .pwrite_in     (pwrite_in),
    .pwdata_in     (pwdata_in),
    .prdata_out    (prdata_out),
    .pready_out    (pready_out),
    .pslverr_out   (pslverr_out),
    .irq_out       (irq_out),
    .cal_stage_out (cal_stage_out)
);

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
    import diag_pkg::*;
    localparam int ROMW = 13;
    logic                     sys_clk = 1'b0;
    logic                     arst_n = 1'b0;
    logic [ADDR_W-1:0]        paddr = '0;
    logic                     psel = 1'b0;
    logic                     penable = 1'b0;
    logic                     pwrite = 1'b0;
    logic [DATA_W-1:0]        pwdata = '0;
    logic [DATA_W-1:0]        prdata;
    logic                     pready;
    logic                     pslverr;
    logic [13:0]              adc_result = '0;
    logic                     adc_valid = 1'b0;
    logic [NUM_CAL-1:0][11:0] cal_value = '0;
    logic [NUM_CAL-1:0]       cal_valid = '0;
    logic [NUM_LINES-1:0]     supply_low = '0;
    logic [NUM_LINES-1:0]     ground_open = '0;
    logic [NUM_CELLS-1:0]     cell_alert = '0;
    logic                     irq;
    logic [NUM_CAL-1:0][11:0] cal_stage;
    logic [DATA_W-1:0]        rdata;
    logic                     rerr;
    int                       miscompares = 0;
    int                       checks_done = 0;

    always #25 sys_clk = ~sys_clk;

    diag_alert_top #(.ROM_WORDS(ROMW)) u_diag_alert_top (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .adc_result_in(adc_result), .adc_valid_in(adc_valid),
        .cal_value_in(cal_value), .cal_valid_in(cal_valid), .supply_low_in(supply_low),
        .ground_open_in(ground_open), .cell_alert_in(cell_alert), .irq_out(irq), .cal_stage_out(cal_stage)
    );

    // Checksum of the default image: MSB first, zero start, last word low byte only
    function automatic logic [7:0] crc_ref();
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        for (int i = 0; i < 2 * ROMW - 1; i++) begin
            b = (i % 2 == 0 && i < 2 * ROMW - 2) ? 8'h5A : 8'h3C;
            for (int k = 7; k >= 0; k--) begin
                c = (c[7] ^ b[k]) ? ({c[6:0], 1'b0} ^ 8'h4D) : {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_ref

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic err);
        apb(1'b0, a, DATA_ZERO);
        chk(rdata, exp);
        chk(32'(rerr), 32'(err));
    endtask : rd

    task automatic adc(input logic [13:0] v);
        adc_result <= v;
        adc_valid <= 1'b1;
        cyc(1);
        adc_valid <= 1'b0;
        cyc(1);
    endtask : adc

    initial begin
        cyc(5000);
        miscompares++;
        finish_test();
    end

    initial begin
        cyc(4);
        arst_n <= 1'b1;
        cyc(20);
        rd(ADDR_CTRL, DATA_ZERO, 1'b0);
        rd(ADDR_HIGHEST_USED_CELL, 32'h0000_000E, 1'b0);
        rd(ADDR_MASK, DATA_ZERO, 1'b0);
        rd(12'h000, DATA_ZERO, 1'b1);
        rd(ADDR_CAL_WORD, {16'h0000, crc_ref(), 8'h3C}, 1'b0);
        wr(ADDR_CAL_WORD, 32'h0000_FFFF);
        chk(32'(rerr), 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0040);
        cyc(2);
        rd(ADDR_CTRL, 32'h0000_0080, 1'b0);
        cyc(20);
        rd(ADDR_CAL_WORD, {16'h0000, crc_ref(), 8'h3C}, 1'b0);
        rd(ADDR_SUMMARY, 32'h0000_0080, 1'b0);
        wr(ADDR_SUMMARY, 32'h0000_00FF);
        wr(ADDR_MASK, 32'h0000_001F);
        cal_value <= {NUM_CAL{12'h100}};
        for (int s = 0; s < NUM_CAL; s++) begin
            wr(ADDR_CTRL, 32'h0000_0001 << s);
            cyc(3);
            chk(32'(cal_stage[s]), 32'h0000_0FFF);
            wr(ADDR_CTRL, DATA_ZERO);
            cal_valid <= '1;
            cyc(1);
            cal_valid <= '0;
            cyc(2);
            rd(ADDR_SUMMARY, 32'h0000_0001 << s, 1'b0);
            chk(32'(irq), 32'h0000_0001);
            wr(ADDR_SUMMARY, 32'h0000_0001 << s);
            rd(ADDR_SUMMARY, DATA_ZERO, 1'b0);
            chk(32'(irq), DATA_ZERO);
            chk(32'(cal_stage[s]), 32'h0000_0100);
        end
        wr(ADDR_CTRL, 32'h0000_0020);
        adc(14'h0000);
        rd(ADDR_FAULT2, DATA_ZERO, 1'b0);
        adc(14'h0001);
        rd(ADDR_FAULT2, 32'h0000_0001, 1'b0);
        rd(ADDR_SUMMARY, 32'h0000_0020, 1'b0);
        wr(ADDR_CTRL, DATA_ZERO);
        wr(ADDR_FAULT2, 32'h0000_007F);
        for (int i = 0; i < 2 * NUM_LINES; i++) begin
            {ground_open, supply_low} <= 6'h01 << i;
            cyc(4);
            {ground_open, supply_low} <= 6'h00;
            cyc(4);
            rd(ADDR_FAULT2, 32'h0000_0002 << i, 1'b0);
            wr(ADDR_FAULT2, 32'h0000_007F);
        end
        for (int t = 0; t < 2; t++) begin
            wr(ADDR_CELL, 32'h0000_3FFF);
            wr(ADDR_HIGHEST_USED_CELL, (t != 0) ? 32'h0000_000E : 32'h0000_0003);
            cell_alert <= 14'h200C;
            cyc(4);
            cell_alert <= 14'h0000;
            cyc(4);
            rd(ADDR_CELL, (t != 0) ? 32'h0000_200C : 32'h0000_0004, 1'b0);
        end
        rd(ADDR_SUMMARY, 32'h0000_0060, 1'b0);
        wr(ADDR_MASK, 32'h0000_00E0);
        cyc(1);
        chk(32'(irq), 32'h0000_0001);
        wr(ADDR_MASK, DATA_ZERO);
        cyc(4);
        chk(32'(irq), DATA_ZERO);
        finish_test();
    end
endmodule : tb_top
